/* File: logic/ctbo_regs.vh */
// constants for the transfer and bit-operation execution core
`ifndef CTBO_REGS_VH
`define CTBO_REGS_VH

// ****************************************
// register byte offsets and address window codes
// ****************************************
`define CTBO_OFS_CMD      12'h000
`define CTBO_OFS_STAT     12'h004
`define CTBO_OFS_SP       12'h008
`define CTBO_OFS_CYC      12'h00C
`define CTBO_WIN_RF       2'h1
`define CTBO_WIN_IO       2'h2
`define CTBO_WIN_RAM      3'h4

// ****************************************
// command word fields and the status busy bit
// ****************************************
`define CTBO_F_OP_HI      23
`define CTBO_F_OP_LO      19
`define CTBO_F_REG_HI     18
`define CTBO_F_REG_LO     14
`define CTBO_F_IO_HI      13
`define CTBO_F_IO_LO      8
`define CTBO_F_BIT_HI     2
`define CTBO_F_BIT_LO     0
`define CTBO_STAT_BUSY    8

// ****************************************
// flag positions in status_flags_register
// ****************************************
`define CTBO_FLG_C        0
`define CTBO_FLG_Z        1
`define CTBO_FLG_N        2
`define CTBO_FLG_V        3
`define CTBO_FLG_H        5
`define CTBO_FLG_T        6

// ****************************************
// reset values and cycle counts
// ****************************************
`define CTBO_RST_SP       8'h3F
`define CTBO_RST_FLAGS    8'h00
`define CTBO_CYC_ONE      4'h1
`define CTBO_CYC_TWO      4'h2

`endif

/* File: logic/ctbo_core.v */
// execution core for I/O transfer, stack, atomic RAM and bit operations
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`include "ctbo_regs.vh"

module ctbo_core (
  // clock and reset
  input  wire        i_mclk,
  input  wire        i_rst_b,
  // ahb-lite slave
  input  wire        i_hsel,
  input  wire [11:0] i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  output reg  [31:0] o_hrdata,
  output reg         o_hreadyout,
  output reg         o_hresp,
  // control pulses
  output reg         o_break,
  output reg         o_sleep,
  output reg         o_wdog
);

  // ****************************************
  // opcodes
  // ****************************************
  localparam [4:0] OP_IN     = 5'h00;
  localparam [4:0] OP_OUT    = 5'h01;
  localparam [4:0] OP_PUSH   = 5'h02;
  localparam [4:0] OP_POP    = 5'h03;
  localparam [4:0] OP_EXCH   = 5'h04;
  localparam [4:0] OP_LSET   = 5'h05;
  localparam [4:0] OP_LCLR   = 5'h06;
  localparam [4:0] OP_LTOG   = 5'h07;
  localparam [4:0] OP_SHL    = 5'h08;
  localparam [4:0] OP_SHR    = 5'h09;
  localparam [4:0] OP_ROTL   = 5'h0A;
  localparam [4:0] OP_ROTR   = 5'h0B;
  localparam [4:0] OP_SSHR   = 5'h0C;
  localparam [4:0] OP_SWAP   = 5'h0D;
  localparam [4:0] OP_FSET   = 5'h0E;
  localparam [4:0] OP_FCLR   = 5'h0F;
  localparam [4:0] OP_IOSET  = 5'h10;
  localparam [4:0] OP_IOCLR  = 5'h11;
  localparam [4:0] OP_B2F    = 5'h12;
  localparam [4:0] OP_F2B    = 5'h13;
  localparam [4:0] OP_BRK    = 5'h14;
  localparam [4:0] OP_IDLE   = 5'h15;
  localparam [4:0] OP_SLP    = 5'h16;
  localparam [4:0] OP_WDOG   = 5'h17;

  // ****************************************
  // states
  // ****************************************
  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_RUN1   = 2'h1;
  localparam [1:0] ST_RUN2   = 2'h2;

  // ****************************************
  // storage
  // ****************************************
  reg  [7:0]  rf_q   [0:31];
  reg  [7:0]  io_q   [0:63];
  reg  [7:0]  ram_q  [0:63];
  reg  [7:0]  flags_q;
  reg  [7:0]  sp_q;
  reg  [23:0] instr_q;
  reg  [1:0]  state_q;
  reg  [3:0]  cyc_q;
  reg  [7:0]  tmp_reg_q;
  reg  [7:0]  tmp_mem_q;
  reg         ap_q;
  reg         ap_wr_q;
  reg  [11:0] ap_addr_q;

  wire        busy    = (state_q != ST_IDLE);
  wire [4:0]  op      = instr_q[`CTBO_F_OP_HI:`CTBO_F_OP_LO];
  wire [4:0]  rsel    = instr_q[`CTBO_F_REG_HI:`CTBO_F_REG_LO];
  wire [5:0]  asel    = instr_q[`CTBO_F_IO_HI:`CTBO_F_IO_LO];
  wire [2:0]  bsel    = instr_q[`CTBO_F_BIT_HI:`CTBO_F_BIT_LO];
  wire [7:0]  rv      = rf_q[rsel];
  wire [5:0]  zptr    = rf_q[30][5:0];
  wire [7:0]  mv      = ram_q[zptr];
  wire [7:0]  bmask   = 8'h01 << bsel;
  // register accesses wait while an instruction is in flight
  wire        bus_do  = ap_q & ~busy;
  wire        bus_wr  = bus_do & ap_wr_q;
  wire        bus_go  = i_hsel & i_htrans[1] & i_hready;

  // ****************************************
  // shifter and its flags
  // ****************************************
  reg  [7:0]  sh_res;
  reg         sh_c;
  reg  [7:0]  sh_flags;

  always @* begin
    sh_res = rv;
    sh_c   = 1'b0;
    case (op)
      OP_SHL: begin
        sh_res = {rv[6:0], 1'b0};
        sh_c   = rv[7];
      end
      OP_ROTL: begin
        sh_res = {rv[6:0], flags_q[`CTBO_FLG_C]};
        sh_c   = rv[7];
      end
      OP_SHR: begin
        sh_res = {1'b0, rv[7:1]};
        sh_c   = rv[0];
      end
      OP_ROTR: begin
        sh_res = {flags_q[`CTBO_FLG_C], rv[7:1]};
        sh_c   = rv[0];
      end
      OP_SSHR: begin
        sh_res = {rv[7], rv[7:1]};
        sh_c   = rv[0];
      end
      default: begin
        sh_res = rv;
        sh_c   = 1'b0;
      end
    endcase
    sh_flags                = flags_q;
    sh_flags[`CTBO_FLG_C]   = sh_c;
    sh_flags[`CTBO_FLG_Z]   = (sh_res == 8'h00);
    sh_flags[`CTBO_FLG_N]   = sh_res[7];
    sh_flags[`CTBO_FLG_V]   = sh_res[7] ^ sh_c;
    if ((op == OP_SHL) || (op == OP_ROTL)) begin
      sh_flags[`CTBO_FLG_H] = rv[3];
    end
  end

  // ****************************************
  // register read mux
  // ****************************************
  reg  [31:0] rdata;

  always @* begin
    rdata = 32'h0000_0000;
    if (ap_addr_q[11:7] == {3'h0, `CTBO_WIN_RF}) begin
      rdata = {24'h00_0000, rf_q[ap_addr_q[6:2]]};
    end else if (ap_addr_q[11:8] == {2'h0, `CTBO_WIN_IO}) begin
      rdata = {24'h00_0000, io_q[ap_addr_q[7:2]]};
    end else if (ap_addr_q[11:8] == {1'h0, `CTBO_WIN_RAM}) begin
      rdata = {24'h00_0000, ram_q[ap_addr_q[7:2]]};
    end else begin
      case (ap_addr_q)
        `CTBO_OFS_CMD:  rdata = {8'h00, instr_q};
        `CTBO_OFS_STAT: rdata = {23'h00_0000, busy, flags_q};
        `CTBO_OFS_SP:   rdata = {24'h00_0000, sp_q};
        `CTBO_OFS_CYC:  rdata = {28'h000_0000, cyc_q};
        default:        rdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // ahb-lite handshake
  // ****************************************
  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      ap_q        <= 1'b0;
      ap_wr_q     <= 1'b0;
      ap_addr_q   <= 12'h000;
      o_hreadyout <= 1'b1;
      o_hrdata    <= 32'h0000_0000;
      o_hresp     <= 1'b0;
    end else if (bus_go) begin
      ap_q        <= 1'b1;
      ap_wr_q     <= i_hwrite;
      ap_addr_q   <= {i_haddr[11:2], 2'h0};
      o_hreadyout <= 1'b0;
    end else if (bus_do) begin
      ap_q        <= 1'b0;
      o_hreadyout <= 1'b1;
      if (!ap_wr_q) begin
        o_hrdata  <= rdata;
      end
    end
  end

  // ****************************************
  // execution and storage writes
  // ****************************************
  always @(posedge i_mclk) begin
    o_break <= 1'b0;
    o_sleep <= 1'b0;
    o_wdog  <= 1'b0;
    if (!i_rst_b) begin
      state_q   <= ST_IDLE;
      instr_q   <= 24'h00_0000;
      flags_q   <= `CTBO_RST_FLAGS;
      sp_q      <= `CTBO_RST_SP;
      cyc_q     <= 4'h0;
      tmp_reg_q <= 8'h00;
      tmp_mem_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (bus_wr) begin
            if (ap_addr_q[11:7] == {3'h0, `CTBO_WIN_RF}) begin
              rf_q[ap_addr_q[6:2]] <= i_hwdata[7:0];
            end else if (ap_addr_q[11:8] == {2'h0, `CTBO_WIN_IO}) begin
              io_q[ap_addr_q[7:2]] <= i_hwdata[7:0];
            end else if (ap_addr_q[11:8] == {1'h0, `CTBO_WIN_RAM}) begin
              ram_q[ap_addr_q[7:2]] <= i_hwdata[7:0];
            end else if (ap_addr_q == `CTBO_OFS_CMD) begin
              instr_q <= i_hwdata[23:0];
              state_q <= ST_RUN1;
              cyc_q   <= 4'h0;
            end else if (ap_addr_q == `CTBO_OFS_STAT) begin
              flags_q <= i_hwdata[7:0];
            end else if (ap_addr_q == `CTBO_OFS_SP) begin
              sp_q    <= i_hwdata[7:0];
            end
          end
        end
        ST_RUN1: begin
          cyc_q   <= `CTBO_CYC_ONE;
          state_q <= ST_IDLE;
          case (op)
            OP_IN:  rf_q[rsel]  <= io_q[asel];
            OP_OUT: io_q[asel]  <= rv;
            OP_PUSH: begin
              ram_q[sp_q[5:0]] <= rv;
              sp_q             <= sp_q - 8'h01;
            end
            OP_POP: begin
              sp_q    <= sp_q + 8'h01;
              state_q <= ST_RUN2;
            end
            OP_EXCH, OP_LSET, OP_LCLR, OP_LTOG: begin
              tmp_reg_q <= rv;
              tmp_mem_q <= mv;
              state_q   <= ST_RUN2;
            end
            OP_SHL, OP_ROTL: begin
              rf_q[rsel] <= sh_res;
              flags_q    <= sh_flags;
            end
            OP_SHR, OP_ROTR, OP_SSHR: begin
              rf_q[rsel] <= sh_res;
              flags_q    <= sh_flags;
            end
            OP_SWAP: rf_q[rsel] <= {rv[3:0], rv[7:4]};
            OP_FSET: flags_q <= flags_q | bmask;
            OP_FCLR: flags_q <= flags_q & ~bmask;
            OP_IOSET: io_q[asel] <= io_q[asel] | bmask;
            OP_IOCLR: io_q[asel] <= io_q[asel] & ~bmask;
            OP_B2F: flags_q[`CTBO_FLG_T] <= rv[bsel];
            OP_F2B: rf_q[rsel][bsel] <= flags_q[`CTBO_FLG_T];
            OP_BRK:  o_break <= 1'b1;
            OP_SLP:  o_sleep <= 1'b1;
            OP_WDOG: o_wdog  <= 1'b1;
            OP_IDLE: cyc_q   <= `CTBO_CYC_ONE;
            default: cyc_q   <= `CTBO_CYC_ONE;
          endcase
        end
        ST_RUN2: begin
          cyc_q   <= `CTBO_CYC_TWO;
          state_q <= ST_IDLE;
          case (op)
            OP_POP: rf_q[rsel] <= ram_q[sp_q[5:0]];
            OP_EXCH: begin
              rf_q[rsel]  <= tmp_mem_q;
              ram_q[zptr] <= tmp_reg_q;
            end
            OP_LSET: begin
              rf_q[rsel]  <= tmp_mem_q;
              ram_q[zptr] <= tmp_reg_q | tmp_mem_q;
            end
            OP_LCLR: begin
              rf_q[rsel]  <= tmp_mem_q;
              ram_q[zptr] <= ~tmp_reg_q & tmp_mem_q;
            end
            OP_LTOG: begin
              rf_q[rsel]  <= tmp_mem_q;
              ram_q[zptr] <= tmp_reg_q ^ tmp_mem_q;
            end
            default: cyc_q <= `CTBO_CYC_TWO;
          endcase
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // ctbo_core

/* File: test/ctbo_core_asserts.sv */
// checker on the ctbo_core bus and pulse ports
module ctbo_asserts (
  input logic        i_mclk,
  input logic        i_rst_b,
  input logic        i_hsel,
  input logic [1:0]  i_htrans,
  input logic        i_hready,
  input logic [31:0] o_hrdata,
  input logic        o_hreadyout,
  input logic        o_hresp,
  input logic        o_break,
  input logic        o_sleep,
  input logic        o_wdog
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  take_wait_a:
    assert property (i_hsel && i_htrans[1] && i_hready |=> !o_hreadyout)
      else $error("no wait after taken transfer");
  wait_bound_a:
    assert property ($fell(o_hreadyout) |-> ##[1:3] o_hreadyout)
      else $error("wait too long");
  rdata_hold_a:
    assert property (!o_hreadyout ##1 !o_hreadyout |-> $stable(o_hrdata))
      else $error("read data moved in wait");
  resp_okay_a:
    assert property (o_hresp == 1'b0)
      else $error("response not okay");
  brk_pulse_a:
    assert property (o_break |=> !o_break)
      else $error("break pulse too long");
  slp_pulse_a:
    assert property (o_sleep |=> !o_sleep)
      else $error("sleep pulse too long");
  wdog_pulse_a:
    assert property (o_wdog |=> !o_wdog)
      else $error("restart pulse too long");
  pulse_excl_a:
    assert property ($onehot0({o_break, o_sleep, o_wdog}))
      else $error("two pulses at once");
  reset_vals_a:
    assert property (disable iff (1'b0) !i_rst_b |=> o_hreadyout && o_hrdata == 32'h0
      && !o_break && !o_sleep && !o_wdog)
      else $error("bad value in reset");
endmodule // ctbo_asserts

bind ctbo_core ctbo_asserts u_chk (.i_mclk, .i_rst_b, .i_hsel, .i_htrans, .i_hready,
  .o_hrdata, .o_hreadyout, .o_hresp, .o_break, .o_sleep, .o_wdog);

/* File: test/ctbo_ctl_sink.sv */
// far side of the control pulses: counts each kind
module ctbo_ctl_sink (
  // clock and reset
  input  logic       i_mclk,
  input  logic       i_rst_b,
  // pulses from the core
  input  logic       i_break,
  input  logic       i_sleep,
  input  logic       i_wdog,
  // counts
  output logic [3:0] o_n_brk,
  output logic [3:0] o_n_slp,
  output logic [3:0] o_n_wdog
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_n_brk <= 4'h0;
      o_n_slp <= 4'h0;
      o_n_wdog <= 4'h0;
    end else begin
      o_n_brk <= o_n_brk + {3'h0, i_break};
      o_n_slp <= o_n_slp + {3'h0, i_sleep};
      o_n_wdog <= o_n_wdog + {3'h0, i_wdog};
    end
  end
endmodule // ctbo_ctl_sink

/* File: test/tb_cpu_transfer_bit_ops_exec.sv */
// self-checking bench for the transfer and bit-operation core
module tb_cpu_transfer_bit_ops_exec;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_mclk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        i_hsel = 1'b0;
  logic        i_hwrite = 1'b0;
  logic [1:0]  i_htrans = 2'h0;
  logic [11:0] i_haddr = 12'h000;
  logic [31:0] i_hwdata = 32'h0;
  logic [31:0] o_hrdata, q;
  logic        o_hreadyout, o_hresp, o_break, o_sleep, o_wdog;
  logic [3:0]  n_brk, n_slp, n_wdog;
  int          failures = 0;
  int          checks = 0;
  logic [7:0]  atom_e [4] = '{8'h0F, 8'h3F, 8'h30, 8'h33};
  logic [7:0]  sh_r [6] = '{8'h14, 8'h45, 8'h15, 8'hC5, 8'hC5, 8'hA8};
  logic [7:0]  sh_f [6] = '{8'h29, 8'h00, 8'h29, 8'h0C, 8'h0C, 8'h01};

  ctbo_core u_dut (.i_mclk, .i_rst_b, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
    .i_hsize(3'h2), .i_hwdata, .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout,
    .o_hresp, .o_break, .o_sleep, .o_wdog);
  ctbo_ctl_sink u_sink (.i_mclk, .i_rst_b, .i_break(o_break), .i_sleep(o_sleep),
    .i_wdog(o_wdog), .o_n_brk(n_brk), .o_n_slp(n_slp), .o_n_wdog(n_wdog));

  always #5 i_mclk = ~i_mclk;

  // ****
  // bus tasks
  // ****
  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wt;
    int n;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_hreadyout !== 1'b1 && n < 40);
    if (o_hreadyout !== 1'b1) begin
      failures++;
      summarize();
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= a;
    i_hwrite <= w;
    wt();
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    wt();
    q = o_hrdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("[FAIL] %s exp %h got %h", n, e, g);
      failures++;
    end
  endtask
  task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic ex(input logic [4:0] op, r, input logic [5:0] a, input logic [2:0] b);
    xfer(1'b1, 12'h000, {8'h00, op, r, a, 5'h00, b});
  endtask
  function automatic logic [11:0] rf(input logic [4:0] r);
    return 12'h080 + {r, 2'b00};
  endfunction
  function automatic logic [11:0] io(input logic [5:0] a);
    return 12'h200 + {a, 2'b00};
  endfunction
  function automatic logic [11:0] ram(input logic [5:0] a);
    return 12'h400 + {a, 2'b00};
  endfunction

  // ****
  // sequence
  // ****
  initial begin
    repeat (12) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    @(posedge i_mclk);
    rc("stat", 12'h004, 32'h0);
    rc("sp", 12'h008, 32'h3F);
    rc("cyc", 12'h00C, 32'h0);
    wr(12'h800, 32'hFF);
    rc("unmap", 12'h800, 32'h0);
    wr(12'h004, 32'h5A);
    wr(rf(1), 32'hA5);
    ex(5'h01, 5'd1, 6'd3, 3'd0);
    rc("out", io(3), 32'hA5);
    ex(5'h00, 5'd2, 6'd3, 3'd0);
    rc("in", rf(2), 32'hA5);
    rc("cyc", 12'h00C, 32'h1);
    ex(5'h02, 5'd1, 6'd0, 3'd0);
    rc("push", ram(6'h3F), 32'hA5);
    rc("sp", 12'h008, 32'h3E);
    ex(5'h03, 5'd3, 6'd0, 3'd0);
    rc("pop", rf(3), 32'hA5);
    rc("sp", 12'h008, 32'h3F);
    rc("cyc", 12'h00C, 32'h2);
    wr(rf(30), 32'h05);
    for (int k = 0; k < 4; k++) begin
      wr(ram(6'h05), 32'h3C);
      wr(rf(4), 32'h0F);
      ex(5'(4 + k), 5'd4, 6'd0, 3'd0);
      rc("atom reg", rf(4), 32'h3C);
      rc("atom ram", ram(6'h05), {24'h0, atom_e[k]});
      rc("cyc", 12'h00C, 32'h2);
    end
    rc("flags", 12'h004, 32'h5A);
    for (int k = 0; k < 6; k++) begin
      wr(12'h004, 32'h01);
      wr(rf(5), 32'h8A);
      ex(5'(8 + k), 5'd5, 6'd0, 3'd0);
      rc("shift", rf(5), {24'h0, sh_r[k]});
      rc("sflags", 12'h004, {24'h0, sh_f[k]});
    end
    for (int s = 0; s < 8; s++) begin
      wr(12'h004, 32'h00);
      ex(5'h0E, 5'd0, 6'd0, 3'(s));
      rc("fset", 12'h004, 32'h1 << s);
      wr(12'h004, 32'hFF);
      ex(5'h0F, 5'd0, 6'd0, 3'(s));
      rc("fclr", 12'h004, 32'hFF ^ (32'h1 << s));
    end
    wr(io(7), 32'h00);
    ex(5'h10, 5'd0, 6'd7, 3'd6);
    rc("iobit", io(7), 32'h40);
    wr(io(7), 32'hFF);
    ex(5'h11, 5'd0, 6'd7, 3'd6);
    rc("iobit", io(7), 32'hBF);
    rc("flags", 12'h004, 32'h7F);
    wr(12'h004, 32'h00);
    wr(rf(6), 32'h04);
    ex(5'h12, 5'd6, 6'd0, 3'd2);
    rc("tflag", 12'h004, 32'h40);
    wr(rf(7), 32'h00);
    ex(5'h13, 5'd7, 6'd0, 3'd0);
    rc("tbit", rf(7), 32'h01);
    for (int k = 0; k < 4; k++) begin
      ex(5'(20 + k), 5'd0, 6'd0, 3'd0);
      rc("cyc", 12'h00C, 32'h1);
    end
    rc("flags", 12'h004, 32'h40);
    chk("pulses", 32'h111, {20'h0, n_brk, n_slp, n_wdog});
    summarize();
  end
endmodule // tb_cpu_transfer_bit_ops_exec
